// >>> inc/ckgen_pkg.sv
// Shared constants for the clock generator and its register controller
package ckgen_pkg;

  localparam int unsigned  ACC_W      = 24;
  localparam int unsigned  CLK_KHZ    = 125000;
  // Model clocks are tick streams scaled down by this factor to fit under clk_i
  localparam int unsigned  RATE_SCALE = 16;
  localparam logic [23:0]  ACC_MOD    = 24'(CLK_KHZ * RATE_SCALE);
  localparam logic [23:0]  OSC_KHZ_DEF = 24'h002ee0;  // 12000 kHz
  localparam int unsigned  LOCK_TICKS = 8;
  localparam int unsigned  NBR        = 5;

  typedef enum int unsigned {BR_SYS, BR_FLASH, BR_CARD, BR_SERIAL, BR_REV} ckgen_branch_t;

  // A zero entry means the oscillator clock, except CARD_KHZ entry 7, which gives half of it
  localparam logic [23:0] SYS_KHZ   [4] = '{24'h0, 24'h005dc0, 24'h007530, 24'h009c40};
  localparam logic [23:0] FLASH_KHZ [8] = '{24'h0, 24'h00ea60, 24'h00bb80, 24'h009c40,
                                            24'h007530, 24'h005dc0, 24'h004e20, 24'h003e80};
  localparam logic [23:0] CARD_KHZ  [8] = '{24'h0, 24'h00ea60, 24'h00bb80, 24'h007530,
                                            24'h005dc0, 24'h004e20, 24'h003e80, 24'h0};
  localparam logic [23:0] REV_KHZ   [4] = '{24'h002ee0, 24'h003e80, 24'h004e20, 24'h002ee0};
  localparam logic [23:0] SERIAL_KHZ    = 24'h01d4c0;  // 120000 kHz

  localparam logic [1:0] REV_DIVIDED = 2'h3;
  localparam logic [2:0] CARD_OSC_HALF = 3'h7;

  // Register offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_SEL    = 8'h04;
  localparam logic [7:0] OFS_PLL    = 8'h08;
  localparam logic [7:0] OFS_CARD   = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;

  // CTRL fields
  localparam int unsigned CTRL_X2 = 0;
  localparam int unsigned CTRL_MASTER = 1;
  localparam int unsigned CTRL_PLL = 2;
  localparam int unsigned CTRL_FLASH = 3;
  localparam int unsigned CTRL_CARD = 4;
  localparam int unsigned CTRL_SERIAL = 5;
  localparam int unsigned CTRL_W = 6;
  // SEL fields: sys [1:0], flash [4:2], serial [5]
  localparam int unsigned SEL_SYS = 0;
  localparam int unsigned SEL_FLASH = 2;
  localparam int unsigned SEL_SERIAL = 5;
  localparam int unsigned SEL_W = 6;
  // PLL fields: ref div [3:0], rev div [7:4], rev select [9:8]
  localparam int unsigned PLL_REF = 0;
  localparam int unsigned PLL_REVDIV = 4;
  localparam int unsigned PLL_REVSEL = 8;
  localparam int unsigned PLL_W = 10;
  // CARD fields: select [2:0], divider [7:3]
  localparam int unsigned CARD_SEL = 0;
  localparam int unsigned CARD_DIV = 3;
  localparam int unsigned CARD_W = 8;

  localparam logic [CTRL_W-1:0] CTRL_RST = 6'h00;
  localparam logic [SEL_W-1:0]  SEL_RST  = 6'h00;
  localparam logic [PLL_W-1:0]  PLL_RST  = 10'h000;
  localparam logic [CARD_W-1:0] CARD_RST = 8'h00;

endpackage

// >>> inc/ckgen_if.sv
// Configuration and status link between register controller and clock generator
`timescale 1ns/1ps
`default_nettype none
interface ckgen_if;
  logic       master_en;
  logic       pll_en;
  logic       double_speed;
  logic       flash_en;
  logic       card_en;
  logic       serial_en;
  logic [1:0] sys_sel;
  logic [2:0] flash_sel;
  logic       serial_sel;
  logic [3:0] ref_div;
  logic [3:0] rev_div;
  logic [1:0] rev_sel;
  logic [2:0] card_sel;
  logic [4:0] card_div;
  logic       lock;

  modport dev (input master_en, pll_en, double_speed, flash_en, card_en, serial_en, sys_sel,
               flash_sel, serial_sel, ref_div, rev_div, rev_sel, card_sel, card_div, output lock);
  modport ctl (output master_en, pll_en, double_speed, flash_en, card_en, serial_en, sys_sel,
               flash_sel, serial_sel, ref_div, rev_div, rev_sel, card_sel, card_div, input lock);
endinterface
`default_nettype wire

// >>> core/ckgen_nco.sv
// Phase accumulator tick source; rate and run changes apply only at a period boundary
`timescale 1ns/1ps
`default_nettype none
module ckgen_nco
  import ckgen_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              srst_i,
  input  wire logic              run_i,
  input  wire logic [ACC_W-1:0]  step_i,
  output logic                   tick_o
);
  logic [ACC_W-1:0] acc_reg;
  logic [ACC_W-1:0] step_reg;
  logic             active_reg;
  logic [ACC_W:0]   sum;
  wire              wrap;
  wire              boundary;

  assign sum      = {1'b0, acc_reg} + {1'b0, step_reg};
  assign wrap     = active_reg && (sum >= {1'b0, ACC_MOD});
  assign boundary = !active_reg || wrap;

  // Sampling run and step only at a boundary keeps every period whole
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      acc_reg    <= '0;
      step_reg   <= '0;
      active_reg <= 1'b0;
      tick_o     <= 1'b0;
    end else begin
      tick_o <= wrap;
      if (boundary) begin
        active_reg <= run_i;
        step_reg   <= step_i;
        acc_reg    <= wrap ? ACC_W'(sum - {1'b0, ACC_MOD}) : '0;
      end else begin
        acc_reg <= ACC_W'(sum);
      end
    end
  end
endmodule
`default_nettype wire

// >>> core/ckgen_gen.sv
// Clock generator: PLL model, system, flash path, card and serial clock branches
////////////////////////////////////////////////////////////////////////////////
////////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
`default_nettype none
module ckgen_gen
  import ckgen_pkg::*;
#(
  parameter logic [ACC_W-1:0] OSC_KHZ = OSC_KHZ_DEF
)(
  input  wire logic  clk_i,
  input  wire logic  srst_i,
  ckgen_if.dev       cfg,
  input  wire logic  idle_i,
  output logic       osc_tick_o,
  output logic       cpu_tick_o,
  output logic       periph_tick_o,
  output logic       flash_tick_o,
  output logic       card_tick_o,
  output logic       serial_tick_o,
  output logic       pll_up_o,
  output logic       pll_down_o
);
  import ckgen_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Branch tick sources
  // The oscillator source runs free; every other branch has its own run term
  logic [ACC_W-1:0] step [NBR];
  logic             run  [NBR];
  logic             br_tick [NBR];
  logic             osc_tick;

  wire pll_ok    = cfg.master_en && cfg.pll_en;
  wire sys_osc   = (cfg.sys_sel == 2'h0);
  wire flash_osc = (FLASH_KHZ[cfg.flash_sel] == '0);
  wire card_half = (cfg.card_sel == CARD_OSC_HALF);
  wire card_osc  = (CARD_KHZ[cfg.card_sel] == '0);

  assign step[BR_SYS]    = sys_osc ? OSC_KHZ : SYS_KHZ[cfg.sys_sel];
  assign step[BR_FLASH]  = flash_osc ? OSC_KHZ : FLASH_KHZ[cfg.flash_sel];
  assign step[BR_CARD]   = card_half ? (OSC_KHZ >> 1) :
                           (card_osc ? OSC_KHZ : CARD_KHZ[cfg.card_sel]);
  assign step[BR_SERIAL] = cfg.serial_sel ? SERIAL_KHZ : OSC_KHZ;
  assign step[BR_REV]    = REV_KHZ[cfg.rev_sel];

  // A PLL-derived source without the PLL would stop the branch rather than run wild
  assign run[BR_SYS]    = sys_osc || pll_ok;
  assign run[BR_FLASH]  = cfg.flash_en && (flash_osc || pll_ok);
  assign run[BR_CARD]   = cfg.card_en && (cfg.card_div != 5'h00) && (card_osc || card_half || pll_ok);
  assign run[BR_SERIAL] = cfg.serial_en && (!cfg.serial_sel || pll_ok);
  assign run[BR_REV]    = cfg.pll_en;

  ckgen_nco u_osc (
    .clk_i  (clk_i),
    .srst_i (srst_i),
    .run_i  (1'b1),
    .step_i (OSC_KHZ),
    .tick_o (osc_tick)
  );

  genvar gi;
  generate
    for (gi = 0; gi < NBR; gi++) begin : g_br
      ckgen_nco u_nco (
        .clk_i  (clk_i),
        .srst_i (srst_i),
        .run_i  (run[gi]),
        .step_i (step[gi]),
        .tick_o (br_tick[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // PLL comparator and lock filter
  // The edge-count error saturates and clears only with the PLL off, so the dividers
  // and the reverse select are best reprogrammed while the PLL is disabled
  logic [3:0] ref_cnt_reg;
  logic [3:0] rev_cnt_reg;
  logic       ref_tick;
  logic       rev_tick;
  logic signed [3:0] diff_reg;
  logic [3:0] lock_cnt_reg;
  logic       lock_reg;

  // The reference divider, and the reverse divider when rev_sel is REV_DIVIDED, count source ticks and fire on the terminal count
  wire rev_divided = (cfg.rev_sel == REV_DIVIDED);
  wire ref_hit     = osc_tick && (ref_cnt_reg >= cfg.ref_div);
  wire rev_hit     = br_tick[BR_REV] && (!rev_divided || rev_cnt_reg >= cfg.rev_div);
  wire near_zero   = (diff_reg >= -4'sd1) && (diff_reg <= 4'sd1);

  assign ref_tick = cfg.pll_en && ref_hit;
  assign rev_tick = cfg.pll_en && rev_hit;

  always_ff @(posedge clk_i) begin
    if (srst_i || !cfg.pll_en) begin
      ref_cnt_reg  <= 4'h0;
      rev_cnt_reg  <= 4'h0;
      diff_reg     <= 4'sd0;
      lock_cnt_reg <= 4'h0;
      lock_reg     <= 1'b0;
      pll_up_o     <= 1'b0;
      pll_down_o   <= 1'b0;
    end else begin
      if (osc_tick) begin
        ref_cnt_reg <= ref_hit ? 4'h0 : ref_cnt_reg + 4'h1;
      end
      if (br_tick[BR_REV]) begin
        rev_cnt_reg <= rev_hit ? 4'h0 : rev_cnt_reg + 4'h1;
      end
      // Coincident edges cancel, so neither pump output pulses
      pll_up_o   <= ref_tick && !rev_tick;
      pll_down_o <= rev_tick && !ref_tick;
      if (ref_tick && !rev_tick && diff_reg != 4'sd7) begin
        diff_reg <= diff_reg + 4'sd1;
      end else if (rev_tick && !ref_tick && diff_reg != -4'sd8) begin
        diff_reg <= diff_reg - 4'sd1;
      end
      // Lock needs a run of reference edges with the phase error inside one edge
      if (!near_zero) begin
        lock_cnt_reg <= 4'h0;
        lock_reg     <= 1'b0;
      end else if (ref_tick) begin
        if (lock_cnt_reg == 4'(LOCK_TICKS - 1)) begin
          lock_reg <= 1'b1;
        end else begin
          lock_cnt_reg <= lock_cnt_reg + 4'h1;
        end
      end
    end
  end

  assign cfg.lock = lock_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // System, CPU and peripheral clocks, and card divider
  logic       half_reg;
  logic [4:0] card_cnt_reg;
  logic [4:0] card_lim_reg;

  // Standard mode keeps every other system tick, halving the rate
  wire sys_tick    = br_tick[BR_SYS];
  wire periph_tick = sys_tick && (cfg.double_speed || half_reg);
  wire card_due    = (5'(card_cnt_reg + 5'h1) >= card_lim_reg);

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      half_reg      <= 1'b0;
      card_cnt_reg  <= 5'h00;
      card_lim_reg  <= 5'h00;
      osc_tick_o    <= 1'b0;
      cpu_tick_o    <= 1'b0;
      periph_tick_o <= 1'b0;
      flash_tick_o  <= 1'b0;
      card_tick_o   <= 1'b0;
      serial_tick_o <= 1'b0;
    end else begin
      if (sys_tick) begin
        half_reg <= !half_reg;
      end
      osc_tick_o    <= osc_tick;
      periph_tick_o <= periph_tick;
      // Idle gates only the CPU stream; peripherals keep their time base
      cpu_tick_o    <= periph_tick && !idle_i;
      flash_tick_o  <= br_tick[BR_FLASH];
      serial_tick_o <= br_tick[BR_SERIAL];
      card_tick_o   <= 1'b0;
      // The divisor is sampled at an output edge, or while the branch is stopped at count zero, so a change never clips a period
      if (!run[BR_CARD] && card_cnt_reg == 5'h00) begin
        card_lim_reg <= cfg.card_div;
      end else if (br_tick[BR_CARD]) begin
        if (card_due) begin
          card_tick_o  <= 1'b1;
          card_cnt_reg <= 5'h00;
          card_lim_reg <= cfg.card_div;
        end else begin
          card_cnt_reg <= card_cnt_reg + 5'h01;
        end
      end
    end
  end
endmodule
`default_nettype wire

// >>> core/ckgen_ctl.sv
// APB register controller driving the clock generator configuration
`timescale 1ns/1ps
`default_nettype none
module ckgen_ctl
  import ckgen_pkg::*;
(
  input  wire logic         clk_i,
  input  wire logic         srst_i,
  input  wire logic         psel_i,
  input  wire logic         penable_i,
  input  wire logic         pwrite_i,
  input  wire logic [7:0]   paddr_i,
  input  wire logic [31:0]  pwdata_i,
  output logic [31:0]       prdata_o,
  output logic              pready_o,
  output logic              pslverr_o,
  ckgen_if.ctl              cfg
);
  import ckgen_pkg::*;

  logic [CTRL_W-1:0] ctrl_reg;
  logic [SEL_W-1:0]  sel_reg;
  logic [PLL_W-1:0]  pll_reg;
  logic [CARD_W-1:0] card_reg;

  wire access  = psel_i && penable_i;
  wire hit_ctl = (paddr_i == OFS_CTRL);
  wire hit_sel = (paddr_i == OFS_SEL);
  wire hit_pll = (paddr_i == OFS_PLL);
  wire hit_crd = (paddr_i == OFS_CARD);
  wire hit_sts = (paddr_i == OFS_STATUS);
  wire mapped  = hit_ctl || hit_sel || hit_pll || hit_crd || hit_sts;
  wire wr      = access && pwrite_i;

  // Zero wait states; unmapped addresses and status writes answer with an error
  assign pready_o  = 1'b1;
  assign pslverr_o = access && (!mapped || (pwrite_i && hit_sts));

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ctrl_reg <= CTRL_RST;
      sel_reg  <= SEL_RST;
      pll_reg  <= PLL_RST;
      card_reg <= CARD_RST;
      prdata_o <= 32'h0000_0000;
    end else begin
      if (wr && hit_ctl) ctrl_reg <= pwdata_i[CTRL_W-1:0];
      if (wr && hit_sel) sel_reg  <= pwdata_i[SEL_W-1:0];
      if (wr && hit_pll) pll_reg  <= pwdata_i[PLL_W-1:0];
      if (wr && hit_crd) card_reg <= pwdata_i[CARD_W-1:0];
      if (psel_i && !penable_i && !pwrite_i) begin
        prdata_o <= hit_ctl ? {26'h0, ctrl_reg} :
                    hit_sel ? {26'h0, sel_reg} :
                    hit_pll ? {22'h0, pll_reg} :
                    hit_crd ? {24'h0, card_reg} :
                    hit_sts ? {31'h0, cfg.lock} : 32'h0000_0000;
      end
    end
  end

  // Ordering of card programming and lock waits is left to software
  assign cfg.double_speed = ctrl_reg[CTRL_X2];
  assign cfg.master_en    = ctrl_reg[CTRL_MASTER];
  assign cfg.pll_en       = ctrl_reg[CTRL_PLL];
  assign cfg.flash_en     = ctrl_reg[CTRL_FLASH];
  assign cfg.card_en      = ctrl_reg[CTRL_CARD];
  assign cfg.serial_en    = ctrl_reg[CTRL_SERIAL];
  assign cfg.sys_sel      = sel_reg[SEL_SYS +: 2];
  assign cfg.flash_sel    = sel_reg[SEL_FLASH +: 3];
  assign cfg.serial_sel   = sel_reg[SEL_SERIAL];
  assign cfg.ref_div      = pll_reg[PLL_REF +: 4];
  assign cfg.rev_div      = pll_reg[PLL_REVDIV +: 4];
  assign cfg.rev_sel      = pll_reg[PLL_REVSEL +: 2];
  assign cfg.card_sel     = card_reg[CARD_SEL +: 3];
  assign cfg.card_div     = card_reg[CARD_DIV +: 5];
endmodule
`default_nettype wire

// >>> bench/ckgen_assertions.sv
// Concurrent checks on the configuration link and the generated tick streams
`timescale 1ns/1ps
`default_nettype none
module ckgen_assertions (
  input wire logic       clk_i,
  input wire logic       srst_i,
  input wire logic       master_en,
  input wire logic       pll_en,
  input wire logic       flash_en,
  input wire logic       card_en,
  input wire logic       serial_en,
  input wire logic [2:0] flash_sel,
  input wire logic       serial_sel,
  input wire logic [2:0] card_sel,
  input wire logic [4:0] card_div,
  input wire logic       lock,
  input wire logic       idle_i,
  input wire logic       osc_tick_o,
  input wire logic       cpu_tick_o,
  input wire logic       periph_tick_o,
  input wire logic       flash_tick_o,
  input wire logic       card_tick_o,
  input wire logic       serial_tick_o,
  input wire logic       pll_up_o,
  input wire logic       pll_down_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  ////////////////////////////////////////////////////////////////////////////////
  // A branch may finish its current period after a stop, so count idle cycles first
  logic [15:0] fl_off, cd_off, se_off;
  wire logic pll_ok  = master_en && pll_en;
  wire logic fl_stop = !flash_en || (flash_sel != 3'h0 && !pll_ok);
  wire logic cd_stop = !card_en || card_div == 5'h0 || (card_sel != 3'h0 && card_sel != 3'h7 && !pll_ok);
  wire logic se_stop = !serial_en || (serial_sel && !pll_ok);
  always_ff @(posedge clk_i) begin
    fl_off <= (srst_i || !fl_stop) ? 16'h0 : fl_off + 16'(fl_off != 16'hffff);
    cd_off <= (srst_i || !cd_stop) ? 16'h0 : cd_off + 16'(cd_off != 16'hffff);
    se_off <= (srst_i || !se_stop) ? 16'h0 : se_off + 16'(se_off != 16'hffff);
  end
  ////////////////////////////////////////////////////////////////////////////////
  AST_RST_QUIET: assert property ($past(srst_i) |-> !(osc_tick_o || cpu_tick_o || periph_tick_o ||
    flash_tick_o || card_tick_o || serial_tick_o || pll_up_o || pll_down_o || lock)) else $error("tick after reset");
  // CPU and peripheral ticks leave the same edge; idle is the value sampled one edge earlier
  AST_CPU_IDLE: assert property (cpu_tick_o |-> periph_tick_o && !$past(idle_i))
    else $error("cpu tick without cause");
  AST_CPU_FOLLOW: assert property (periph_tick_o && !$past(idle_i) |-> cpu_tick_o)
    else $error("cpu tick missing");
  AST_UPDOWN_EXCL: assert property (pll_up_o |-> !pll_down_o) else $error("up and down together");
  AST_LOCK_DROP: assert property (!pll_en [*2] |-> !lock) else $error("lock while pll off");
  AST_LOCK_SETTLE: assert property ($rose(lock) |-> $past(pll_en, 8)) else $error("lock too early");
  AST_FLASH_GATE: assert property (fl_off > 16'd400 |-> !flash_tick_o) else $error("flash tick while off");
  AST_CARD_GATE: assert property (cd_off > 16'd11000 |-> !card_tick_o) else $error("card tick while off");
  AST_SERIAL_GATE: assert property (se_off > 16'd400 |-> !serial_tick_o) else $error("serial tick while off");
  AST_SERIAL_PULSE: assert property (serial_tick_o |=> !serial_tick_o [*8]) else $error("short serial period");
  AST_FLASH_PULSE: assert property (flash_tick_o |=> !flash_tick_o [*8]) else $error("short flash period");
endmodule
`default_nettype wire

// >>> bench/pll_clock_selectors_bench.sv
// Self-checking bench: APB controller and clock generator joined by the link
`timescale 1ns/1ps
`default_nettype none
module pll_clock_selectors_bench;
  import ckgen_pkg::*;
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_errors++; \
  $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
  localparam int OSC = 12000;
  localparam int W   = 2000;
  logic        clk_i = 1'b0, srst_i = 1'b1, idle_i = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, rerr;
  logic [7:0]  paddr = 8'h0;
  logic [31:0] pwdata = 32'h0, prdata, rdat, rnd = 32'd34195;
  logic [7:0]  tk;
  int          n_errors = 0, n_tests = 0;
  int          cnt[9];
  logic [31:0] regm[4], mask[4] = '{32'h3f, 32'h3f, 32'h3ff, 32'hff};
  int          sys_k[4] = '{OSC, 24000, 30000, 40000};
  int          fl_k[8] = '{OSC, 60000, 48000, 40000, 30000, 24000, 20000, 16000};
  int          cd_k[8] = '{OSC, 60000, 48000, 30000, 24000, 20000, 16000, OSC / 2};
  int          se_k[2] = '{OSC, 120000};
  // PLL settings and whether the loop must lock with a 12 MHz oscillator
  logic [9:0]  pll_q[$] = {10'h000, 10'h100, 10'h200, 10'h300, 10'h311, 10'h001};
  logic        lk_q[$] = {1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
  ckgen_if cfg_if ();
  ckgen_ctl ckgen_ctl_inst (.clk_i(clk_i), .srst_i(srst_i), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .cfg(cfg_if.ctl));
  ckgen_gen #(.OSC_KHZ(24'(OSC))) ckgen_gen_inst (.clk_i(clk_i), .srst_i(srst_i), .cfg(cfg_if.dev), .idle_i(idle_i),
    .osc_tick_o(tk[0]), .cpu_tick_o(tk[2]), .periph_tick_o(tk[1]), .flash_tick_o(tk[3]), .card_tick_o(tk[4]),
    .serial_tick_o(tk[5]), .pll_up_o(tk[6]), .pll_down_o(tk[7]));
  ckgen_assertions ckgen_assertions_inst (.clk_i(clk_i), .srst_i(srst_i), .master_en(cfg_if.master_en),
    .pll_en(cfg_if.pll_en), .flash_en(cfg_if.flash_en), .card_en(cfg_if.card_en), .serial_en(cfg_if.serial_en),
    .flash_sel(cfg_if.flash_sel), .serial_sel(cfg_if.serial_sel), .card_sel(cfg_if.card_sel),
    .card_div(cfg_if.card_div), .lock(cfg_if.lock), .idle_i(idle_i), .osc_tick_o(tk[0]), .cpu_tick_o(tk[2]),
    .periph_tick_o(tk[1]), .flash_tick_o(tk[3]), .card_tick_o(tk[4]), .serial_tick_o(tk[5]), .pll_up_o(tk[6]),
    .pll_down_o(tk[7]));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  always #4 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    rnd <= xs(rnd);
    idle_i <= rnd[0];
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic acc(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    @(posedge clk_i);
    while (pready !== 1'b1) @(posedge clk_i);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input int i, input logic [31:0] d);
    acc(8'(i * 4), 1'b1, d);
    regm[i] = d & mask[i];
  endtask
  task automatic rd(input int i);
    acc(8'(i * 4), 1'b0, 32'h0);
    `CHK("register", regm[i], rdat)
  endtask
  task automatic near(input string nm, input int e, input int got);
    `CHK(nm, e, ((got - e) inside {[-1:1]}) ? e : got)
  endtask
  task automatic rate(input string nm, input int got, input int khz);
    near(nm, int'(longint'(W) * khz / (CLK_KHZ * RATE_SCALE)), got);
  endtask
  // Settle past one old period, then count every tick stream and the cpu model
  task automatic meas();
    logic ip;
    cnt = '{default: 0};
    repeat (400) @(posedge clk_i);
    ip = idle_i;
    repeat (W) begin
      @(posedge clk_i);
      for (int k = 0; k < 8; k++) cnt[k] += int'(tk[k]);
      // The cpu gate acts on idle as it stood one edge before the tick
      cnt[8] += int'(tk[1] && !ip);
      ip = idle_i;
    end
  endtask
  task automatic wait_lock();
    rdat = 32'h0;
    for (int t = 0; t < 40 && rdat[0] !== 1'b1; t++) begin
      repeat (200) @(posedge clk_i);
      acc(OFS_STATUS, 1'b0, 32'h0);
    end
    `CHK("lock", 1'b1, rdat[0])
  endtask
  task automatic end_sim();
    if (n_errors == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (120000) @(posedge clk_i);
    n_errors++;
    end_sim();
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge clk_i);
    srst_i <= 1'b0;
    for (int i = 0; i < 4; i++) regm[i] = 32'h0;
    for (int i = 0; i < 4; i++) rd(i);
    acc(OFS_STATUS, 1'b0, 32'h0);
    `CHK("status reset", 32'h0, rdat)
    for (int i = 0; i < 4; i++) wr(i, rnd);
    for (int i = 0; i < 4; i++) rd(i);
    acc(8'h14, 1'b1, 32'hffffffff);
    `CHK("unmapped err", 1'b1, rerr)
    acc(OFS_STATUS, 1'b1, 32'hffffffff);
    `CHK("status write err", 1'b1, rerr)
    rd(0);
    for (int i = 0; i < 4; i++) wr(i, 32'h0);
    meas();
    rate("osc", cnt[0], OSC);
    rate("periph std", cnt[1], OSC / 2);
    near("cpu", cnt[8], cnt[2]);
    wr(0, 32'h1);
    meas();
    rate("periph x2", cnt[1], OSC);
    wr(0, 32'h7);
    wait_lock();
    // The loop's error count only clears with the PLL off, so each setting is loaded that way
    foreach (pll_q[k]) begin
      wr(0, 32'h3);
      wr(2, 32'(pll_q[k]));
      wr(0, 32'h7);
      meas();
      repeat (1500) @(posedge clk_i);
      acc(OFS_STATUS, 1'b0, 32'h0);
      `CHK("lock table", lk_q[k], rdat[0])
      if (pll_q[k] == 10'h100) `CHK("down over up", 1'b1, cnt[7] > cnt[6])
    end
    wr(0, 32'h3);
    wr(2, 32'h0);
    wr(0, 32'h7);
    wait_lock();
    for (int i = 1; i < 4; i++) begin
      wr(1, 32'(i));
      meas();
      rate("sys", cnt[1], sys_k[i]);
    end
    wr(0, 32'hf);
    for (int i = 0; i < 8; i++) begin
      wr(1, 32'(i << 2));
      meas();
      rate("flash", cnt[3], fl_k[i]);
    end
    wr(0, 32'h7);
    meas();
    rate("flash off", cnt[3], 0);
    wr(3, 32'h9);
    wr(0, 32'h17);
    for (int i = 0; i < 8; i++) begin
      wr(3, 32'h8 | 32'(i));
      meas();
      rate("card", cnt[4], cd_k[i]);
    end
    wr(3, 32'h19);
    meas();
    rate("card div3", cnt[4], 20000);
    wr(3, 32'h1);
    meas();
    rate("card div0", cnt[4], 0);
    wr(0, 32'h27);
    for (int i = 0; i < 2; i++) begin
      wr(1, 32'(i << 5));
      meas();
      rate("serial", cnt[5], se_k[i]);
    end
    wr(0, 32'h7);
    meas();
    rate("serial off", cnt[5], 0);
    wr(1, 32'h24);
    wr(0, 32'h2d);
    meas();
    rate("flash no master", cnt[3], 0);
    rate("serial no master", cnt[5], 0);
    end_sim();
  end
endmodule
`default_nettype wire
